// file: logic/qpwm_timer.sv
// four channel 8-bit pwm timer with avalon-mm register slave
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

// Function
// - four independent 8-bit channels, each with counter, period, duty, one output bit.
// - counter equal to period starts new period: output to start level, counter cleared.
// - counter equal to duty inverts the output for the rest of the period.
// - period and duty buffered, taken into use only when counter clears.
// - any counter write, except a joined high byte write, clears it to zero; counter always readable.
// - period and duty registers readable and writable at any time.
// - clock choice bit: channels 1,2 pick A or S; channels 3,4 pick B or S.
// - clock A is E divided by 1, 2, 4 or 8 per two-bit field.
// - clock B is E divided by two to the three-bit field value.
// - clock S is clock A divided by divisor then two; zero means 256.
// - join bit makes pair one 16-bit channel; low channel clocks and drives pin.
// - when joined, the high channel pin is released for general use.
// - joined high byte read latches low byte for a coherent following read.
// - joined low counter write clears all 16 bits; high counter write ignored.
// - start level 0 begins low, goes high at duty; 1 begins high, goes low.
// - enable bits 3..0 switch channels off or on and onto their output bits.
// - test bit makes clock S observable through the divisor register.
// - test bit stops a period match from clearing the counter.
module qpwm_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // special test mode strap, gates the two test bits
  input wire logic test_mode,
  // avalon-mm slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // output port
  output logic [3:0] pwm_out,
  output logic [3:0] pwm_pin_owned
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] clock_prescale_join_reg;
  logic [7:0] polarity_clock_choice_reg;
  logic [7:0] scaled_clock_divisor;
  logic [7:0] channel_on_reg;
  logic [7:0] per_buf [4];
  logic [7:0] dty_buf [4];
  logic [7:0] per_act [4];
  logic [7:0] dty_act [4];
  logic [7:0] channel_counter [4];
  logic [3:0] level;
  logic [7:0] low_latch [2];
  logic [1:0] latch_valid;
  logic [6:0] e_count;
  logic [7:0] s_count;
  logic s_level;

  // decoded fields
  logic [1:0] join_pair;
  logic [1:0] clock_a_prescale_field;
  logic [2:0] clock_b_prescale_field;
  logic [3:0] channel_clock_choice_bit;
  logic [3:0] channel_start_level_bit;
  logic [3:0] channel_on_bit;
  logic period_clear_inhibit_test;
  logic scaled_clock_observe_test;

  assign join_pair = {clock_prescale_join_reg[qpwm_pkg::JOIN_PAIR_HIGH_POS],
                      clock_prescale_join_reg[qpwm_pkg::JOIN_PAIR_LOW_POS]};
  assign clock_a_prescale_field = clock_prescale_join_reg[qpwm_pkg::CLOCK_A_PRESCALE_LSB +: 2];
  assign clock_b_prescale_field = clock_prescale_join_reg[qpwm_pkg::CLOCK_B_PRESCALE_LSB +: 3];
  assign channel_clock_choice_bit = polarity_clock_choice_reg[qpwm_pkg::CLOCK_CHOICE_LSB +: 4];
  assign channel_start_level_bit = polarity_clock_choice_reg[qpwm_pkg::START_LEVEL_LSB +: 4];
  assign channel_on_bit = channel_on_reg[qpwm_pkg::CHANNEL_ON_LSB +: 4];
  assign period_clear_inhibit_test = channel_on_reg[qpwm_pkg::PERIOD_CLEAR_INHIBIT_POS];
  assign scaled_clock_observe_test = channel_on_reg[qpwm_pkg::SCALED_CLOCK_OBSERVE_POS];

  // ---------------------------------------------------------------
  // bus handshake and decode
  // ---------------------------------------------------------------
  logic wr_go;
  logic rd_go;
  logic [7:0] idx;
  logic aligned;
  logic wr_sel;
  logic [7:0] wbyte;

  assign wr_go = avs_write && !avs_waitrequest;
  assign rd_go = avs_read && !avs_waitrequest;
  assign idx = avs_address[9:2];
  assign aligned = (avs_address[1:0] == 2'b00);
  assign wr_sel = wr_go && aligned && avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  // one wait cycle per access: low for exactly the cycle that completes it
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // counter write strobes, joined high byte writes are dropped
  logic [3:0] cnt_clear;
  for (genvar c = 0; c < 4; c++) begin : g_clr
    assign cnt_clear[c] = wr_sel && (idx == qpwm_pkg::IDX_COUNTER_BASE + 8'(c));
  end

  // ---------------------------------------------------------------
  // control register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      clock_prescale_join_reg <= qpwm_pkg::RESET_CLOCK_PRESCALE_JOIN;
      polarity_clock_choice_reg <= qpwm_pkg::RESET_POLARITY_CLOCK_CHOICE;
      scaled_clock_divisor <= qpwm_pkg::RESET_SCALED_CLOCK_DIVISOR;
      channel_on_reg <= qpwm_pkg::RESET_CHANNEL_ENABLE;
    end else if (wr_sel) begin
      if (idx == qpwm_pkg::IDX_CLOCK_PRESCALE_JOIN) begin
        clock_prescale_join_reg <= wbyte;
      end
      if (idx == qpwm_pkg::IDX_POLARITY_CLOCK_CHOICE) begin
        polarity_clock_choice_reg <= wbyte;
      end
      if (idx == qpwm_pkg::IDX_SCALED_CLOCK_DIVISOR) begin
        scaled_clock_divisor <= wbyte;
      end
      if (idx == qpwm_pkg::IDX_CHANNEL_ENABLE) begin
        channel_on_reg[3:0] <= wbyte[3:0];
        if (test_mode) begin
          channel_on_reg[7:6] <= wbyte[7:6];
        end
      end
    end
  end

  // period and duty buffers, writable at any time
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      for (int k = 0; k < 4; k++) begin
        per_buf[k] <= qpwm_pkg::RESET_CHANNEL_BYTE;
        dty_buf[k] <= qpwm_pkg::RESET_CHANNEL_BYTE;
      end
    end else if (wr_sel) begin
      for (int k = 0; k < 4; k++) begin
        if (idx == qpwm_pkg::IDX_PERIOD_BASE + 8'(k)) begin
          per_buf[k] <= wbyte;
        end
        if (idx == qpwm_pkg::IDX_DUTY_BASE + 8'(k)) begin
          dty_buf[k] <= wbyte;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // clock enables A, B and S
  // ---------------------------------------------------------------
  logic tick_a;
  logic tick_b;
  logic tick_s;
  logic [6:0] mask_a;
  logic [6:0] mask_b;
  logic s_wrap;

  assign mask_a = 7'((8'h01 << clock_a_prescale_field) - 8'h01);
  assign mask_b = 7'((8'h01 << clock_b_prescale_field) - 8'h01);
  assign tick_a = ((e_count & mask_a) == mask_a);
  assign tick_b = ((e_count & mask_b) == mask_b);
  assign s_wrap = tick_a && (s_count == 8'(scaled_clock_divisor - 8'h01));
  assign tick_s = s_wrap && s_level;

  // free running prescaler on the system clock
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      e_count <= 7'h00;
    end else begin
      e_count <= 7'(e_count + 7'h01);
    end
  end

  // divisor counter: zero wraps after 256 ticks, s_level halves again
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_count <= 8'h00;
      s_level <= 1'b0;
    end else if (tick_a) begin
      if (s_wrap) begin
        s_count <= 8'h00;
        s_level <= !s_level;
      end else begin
        s_count <= 8'(s_count + 8'h01);
      end
    end
  end

  // ---------------------------------------------------------------
  // channel pairs
  // ---------------------------------------------------------------
  logic [3:0] ch_tick;
  assign ch_tick[0] = channel_clock_choice_bit[0] ? tick_s : tick_a;
  assign ch_tick[1] = channel_clock_choice_bit[1] ? tick_s : tick_a;
  assign ch_tick[2] = channel_clock_choice_bit[2] ? tick_s : tick_b;
  assign ch_tick[3] = channel_clock_choice_bit[3] ? tick_s : tick_b;

  // ---------------------------------------------------------------
  // per channel counters
  // ---------------------------------------------------------------
  // one process per channel so that no array element has two writers;
  // a joined pair steps its two bytes together as one 16-bit count
  for (genvar c = 0; c < 4; c++) begin : g_chan
    localparam int P = c / 2;
    localparam int H = 2 * P;
    localparam int L = 2 * P + 1;
    localparam int LOW_BYTE = c % 2;

    // pair-wide views: both channels of a pair see the same 16-bit numbers
    logic [15:0] cnt16;
    logic [15:0] per16;
    logic [15:0] dty16;
    logic [15:0] inc16;
    logic [7:0] inc_byte;
    logic [7:0] next_count;

    assign cnt16 = {channel_counter[H], channel_counter[L]};
    assign per16 = {per_act[H], per_act[L]};
    assign dty16 = {dty_act[H], dty_act[L]};
    assign inc16 = 16'(cnt16 + 16'h0001);
    // each byte of a joined pair takes its own half of the 16-bit sum
    assign inc_byte = (LOW_BYTE == 1) ? inc16[7:0] : inc16[15:8];
    assign next_count = 8'(channel_counter[c] + 8'h01);

    // counter, buffers in use and output level of this channel
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        channel_counter[c] <= qpwm_pkg::RESET_CHANNEL_BYTE;
        per_act[c] <= qpwm_pkg::RESET_CHANNEL_BYTE;
        dty_act[c] <= qpwm_pkg::RESET_CHANNEL_BYTE;
        level[c] <= 1'b0;
      end else if (join_pair[P]) begin
        // 16-bit mode: low channel owns clock, enable, start level and pin
        // only a low byte write clears; a high byte write is dropped
        if (cnt_clear[L]) begin
          channel_counter[c] <= 8'h00;
          per_act[c] <= per_buf[c];
          dty_act[c] <= dty_buf[c];
          level[c] <= channel_start_level_bit[L];
        end else if (channel_on_bit[L] && ch_tick[L]) begin
          if (cnt16 == per16 && !period_clear_inhibit_test) begin
            channel_counter[c] <= 8'h00;
            per_act[c] <= per_buf[c];
            dty_act[c] <= dty_buf[c];
            level[c] <= channel_start_level_bit[L];
          end else begin
            channel_counter[c] <= inc_byte;
            if (cnt16 == dty16) begin
              level[c] <= !channel_start_level_bit[L];
            end
          end
        end
      end else begin
        // separate 8-bit channel
        if (cnt_clear[c]) begin
          channel_counter[c] <= 8'h00;
          per_act[c] <= per_buf[c];
          dty_act[c] <= dty_buf[c];
          level[c] <= channel_start_level_bit[c];
        end else if (channel_on_bit[c] && ch_tick[c]) begin
          if (channel_counter[c] == per_act[c] && !period_clear_inhibit_test) begin
            channel_counter[c] <= 8'h00;
            per_act[c] <= per_buf[c];
            dty_act[c] <= dty_buf[c];
            level[c] <= channel_start_level_bit[c];
          end else begin
            channel_counter[c] <= next_count;
            if (channel_counter[c] == dty_act[c]) begin
              level[c] <= !channel_start_level_bit[c];
            end
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // coherent 16-bit reads
  // ---------------------------------------------------------------
  // low byte snapshot taken by a joined high counter read
  for (genvar p = 0; p < 2; p++) begin : g_pair
    localparam int H = 2 * p;
    localparam int L = 2 * p + 1;
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        low_latch[p] <= 8'h00;
        latch_valid[p] <= 1'b0;
      end else if (rd_go && aligned && join_pair[p]
                   && idx == qpwm_pkg::IDX_COUNTER_BASE + 8'(H)) begin
        low_latch[p] <= channel_counter[L];
        latch_valid[p] <= 1'b1;
      end else if (rd_go || wr_go) begin
        latch_valid[p] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // output port
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pwm_out <= 4'h0;
      pwm_pin_owned <= 4'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        pwm_out[k] <= channel_on_bit[k] && level[k] && !(join_pair[k / 2] && k % 2 == 0);
        pwm_pin_owned[k] <= channel_on_bit[k] && !(join_pair[k / 2] && k % 2 == 0);
      end
    end
  end

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    if (aligned) begin
      for (int k = 0; k < 4; k++) begin
        if (idx == qpwm_pkg::IDX_COUNTER_BASE + 8'(k)) begin
          if (k % 2 == 1 && join_pair[k / 2] && latch_valid[k / 2]) begin
            rd_val = low_latch[k / 2];
          end else begin
            rd_val = channel_counter[k];
          end
        end
        if (idx == qpwm_pkg::IDX_PERIOD_BASE + 8'(k)) begin
          rd_val = per_buf[k];
        end
        if (idx == qpwm_pkg::IDX_DUTY_BASE + 8'(k)) begin
          rd_val = dty_buf[k];
        end
      end
      if (idx == qpwm_pkg::IDX_CLOCK_PRESCALE_JOIN) begin
        rd_val = clock_prescale_join_reg;
      end
      if (idx == qpwm_pkg::IDX_POLARITY_CLOCK_CHOICE) begin
        rd_val = polarity_clock_choice_reg;
      end
      if (idx == qpwm_pkg::IDX_SCALED_CLOCK_DIVISOR) begin
        rd_val = scaled_clock_observe_test ? {7'h00, s_level} : scaled_clock_divisor;
      end
      if (idx == qpwm_pkg::IDX_CHANNEL_ENABLE) begin
        rd_val = {channel_on_reg[7:6], 2'b00, channel_on_reg[3:0]};
      end
    end
  end

  // read data registered in the wait cycle, stands at the completing edge
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= {24'h00_0000, rd_val};
    end
  end

endmodule

// file: logic/qpwm_pkg.sv
// constants for the four channel pwm timer
package qpwm_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CLOCK_PRESCALE_JOIN = 8'h60;
  localparam logic [7:0] IDX_POLARITY_CLOCK_CHOICE = 8'h61;
  localparam logic [7:0] IDX_SCALED_CLOCK_DIVISOR = 8'h62;
  localparam logic [7:0] IDX_CHANNEL_ENABLE = 8'h63;
  localparam logic [7:0] IDX_COUNTER_BASE = 8'h64;
  localparam logic [7:0] IDX_PERIOD_BASE = 8'h68;
  localparam logic [7:0] IDX_DUTY_BASE = 8'h6c;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  // clock prescale / join register
  localparam int JOIN_PAIR_HIGH_POS = 7;
  localparam int JOIN_PAIR_LOW_POS = 6;
  localparam int CLOCK_A_PRESCALE_LSB = 4;
  localparam int CLOCK_B_PRESCALE_LSB = 0;
  // polarity / clock choice register
  localparam int CLOCK_CHOICE_LSB = 4;
  localparam int START_LEVEL_LSB = 0;
  // channel enable register
  localparam int SCALED_CLOCK_OBSERVE_POS = 7;
  localparam int PERIOD_CLEAR_INHIBIT_POS = 6;
  localparam int CHANNEL_ON_LSB = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RESET_CLOCK_PRESCALE_JOIN = 8'h00;
  localparam logic [7:0] RESET_POLARITY_CLOCK_CHOICE = 8'h00;
  localparam logic [7:0] RESET_SCALED_CLOCK_DIVISOR = 8'h00;
  localparam logic [7:0] RESET_CHANNEL_ENABLE = 8'h00;
  localparam logic [7:0] RESET_CHANNEL_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int CHANNELS = 4;
  localparam int PAIRS = 2;
  localparam int PRESCALE_BITS = 7;

endpackage

// file: verif/qpwm_timer_chk.sv
// concurrent checks on the pwm timer register bus and output port
`timescale 1ns/1ps
module qpwm_timer_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // output port
  input wire logic [3:0] pwm_out,
  input wire logic [3:0] pwm_pin_owned
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // ---------------------------------------------------------------
  // bus handshake: one wait cycle, then a single ready cycle
  // ---------------------------------------------------------------
  a_read_answer: assert property ($rose(avs_read) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("read not answered after one wait cycle");
  a_write_answer: assert property ($rose(avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("write not answered after one wait cycle");
  a_wait_cause: assert property (!avs_waitrequest |-> (avs_read || avs_write) && $past(avs_waitrequest))
    else $error("ready without a pending request");
  a_data_upper: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data upper bytes not zero");
  a_data_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");

  // ---------------------------------------------------------------
  // output port follows reset, enables and joining
  // ---------------------------------------------------------------
  a_reset_quiet: assert property ($rose(nrst) |-> avs_waitrequest && avs_readdata == 32'h0
    && pwm_out == 4'h0 && pwm_pin_owned == 4'h0)
    else $error("outputs not idle after reset");
  a_pin_quiet: assert property ((~pwm_pin_owned & ~$past(pwm_pin_owned) & pwm_out) == 4'h0)
    else $error("released pin still driven high");
  a_owned_by_write: assert property ($changed(pwm_pin_owned) |->
    $past(avs_write && !avs_waitrequest) || $past(avs_write && !avs_waitrequest, 2))
    else $error("pin ownership changed without a write");
endmodule

bind qpwm_timer qpwm_timer_chk u_chk (.clk_sys(clk_sys), .nrst(nrst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pwm_out(pwm_out), .pwm_pin_owned(pwm_pin_owned));

// file: verif/qpwm_meter.sv
// pulse meter standing at the pwm output pins
`timescale 1ns/1ps
module qpwm_meter (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // pins under watch
  input wire logic [3:0] pwm_out,
  // report on each rising edge: low run just ended, last high run
  output logic [3:0] meas_valid,
  output logic [3:0][15:0] meas_low,
  output logic [3:0][15:0] meas_high
);
  logic [3:0] prev;
  logic [3:0][15:0] run;

  // ---------------------------------------------------------------
  // run length counters, one per pin
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    for (int k = 0; k < 4; k++) begin
      meas_valid[k] <= 1'b0;
      if (!nrst) begin
        prev[k] <= 1'b0;
        run[k] <= 16'h1;
      end else if (pwm_out[k] != prev[k]) begin
        prev[k] <= pwm_out[k];
        run[k] <= 16'h1;
        if (pwm_out[k]) begin
          meas_low[k] <= run[k];
          meas_valid[k] <= 1'b1;
        end else begin
          meas_high[k] <= run[k];
        end
      end else begin
        run[k] <= run[k] + 16'h1; // wraps harmlessly while a pin sits idle
      end
    end
  end
endmodule

// file: verif/qpwm_timer_tb.sv
// self-checking bench for the four channel pwm timer
`timescale 1ns/1ps
module qpwm_timer_tb;
  typedef struct {int ch; logic [15:0] lo; logic [15:0] hi;} qpwm_wave_type;
  localparam logic [7:0] JIDX [4] = '{8'h68, 8'h69, 8'h6c, 8'h6d};
  localparam logic [7:0] JVAL [4] = '{8'h01, 8'h05, 8'h00, 8'h80};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic test_mode = 1'b0;
  logic [9:0] avs_address = 10'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] pwm_out;
  logic [3:0] pwm_pin_owned;
  logic [3:0] meas_valid;
  logic [3:0][15:0] meas_low;
  logic [3:0][15:0] meas_high;
  logic [31:0] rq[$];
  qpwm_wave_type wq[$];
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int a, b, dv;
  int tk[4];
  logic [7:0] d;
  logic [3:0] pol;
  logic [7:0] per[4];
  logic [7:0] dty[4];

  always #4 clk_sys = ~clk_sys;

  qpwm_timer uut (.clk_sys(clk_sys), .nrst(nrst), .test_mode(test_mode),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pwm_out(pwm_out), .pwm_pin_owned(pwm_pin_owned));
  qpwm_meter meter (.clk_sys(clk_sys), .nrst(nrst), .pwm_out(pwm_out),
    .meas_valid(meas_valid), .meas_low(meas_low), .meas_high(meas_high));

  // ---------------------------------------------------------------
  // reporting and compare tasks
  // ---------------------------------------------------------------
  task automatic test_done;
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic miss(input string msg);
    n_fail++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) miss($sformatf("value %h, want %h", got, exp));
  endtask
  task automatic chk_wave(input logic [15:0] gl, gh, el, eh);
    n_checks++;
    if (gl !== el || gh !== eh) miss($sformatf("low/high %0d/%0d, want %0d/%0d", gl, gh, el, eh));
  endtask

  // ---------------------------------------------------------------
  // bus master: hold the request until waitrequest is sampled low
  // ---------------------------------------------------------------
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] v);
    @(posedge clk_sys);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, v};
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    bus(1'b1, idx, v);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    rq.push_back(exp);
    bus(1'b0, idx, 8'h00);
  endtask
  // low and high widths in cycles of one steady period
  task automatic expect_wave(input int k, input int p, input int du, input int t, input logic sl);
    int f;
    int s;
    f = (du + 1) * t;
    s = (p - du) * t;
    if (sl) wq.push_back('{k, 16'(s), 16'(f)});
    else wq.push_back('{k, 16'(f), 16'(s)});
  endtask

  // watchdog and result monitor: oldest note against each result
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      miss("run too long");
      test_done;
    end else begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rq.size() > 0)
        chk_rd(avs_readdata, rq.pop_front());
      for (int k = 0; k < 4; k++) begin
        if (meas_valid[k] === 1'b1 && wq.size() > 0 && wq[0].ch == k) begin
          chk_wave(meas_low[k], meas_high[k], wq[0].lo, wq[0].hi);
          void'(wq.pop_front());
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(17389));
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    // reset values, unmapped index, period and duty read back
    for (int i = 'h60; i < 'h70; i++) rd(8'(i), 32'h0);
    rd(8'h10, 32'h0);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      wr(8'h68 + 8'(i), d);
      rd(8'h68 + 8'(i), {24'h0, d});
    end
    avs_byteenable <= 4'he;
    wr(8'h6f, ~d);
    avs_byteenable <= 4'h1;
    rd(8'h6f, {24'h0, d});
    // test bits only take a write in special test mode
    wr(8'h63, 8'hff);
    rd(8'h63, 32'h0f);
    test_mode <= 1'b1;
    wr(8'h63, 8'h40);
    rd(8'h63, 32'h40);
    wr(8'h63, 8'h00);
    test_mode <= 1'b0;
    // fixed clock choices (S on the second channel, A or B on the rest), random prescales, polarities on all channels
    for (int it = 0; it < 3; it++) begin
      a = $urandom % 4;
      b = $urandom % 8;
      dv = 1 + $urandom % 3;
      pol = 4'($urandom);
      tk = '{1 << a, 2 * dv << a, 1 << b, 1 << b};
      wr(8'h60, {2'b00, a[1:0], 1'b0, b[2:0]});
      wr(8'h61, {4'b0010, pol});
      wr(8'h62, dv[7:0]);
      for (int k = 0; k < 4; k++) begin
        per[k] = 8'(3 + $urandom % 6);
        dty[k] = 8'($urandom % per[k]);
        wr(8'h68 + 8'(k), per[k]);
        wr(8'h6c + 8'(k), dty[k]);
      end
      wr(8'h63, 8'h0f);
      for (int k = 0; k < 4; k++) wr(8'h64 + 8'(k), 8'($urandom));
      repeat (2500) @(posedge clk_sys);
      chk_rd({28'h0, pwm_pin_owned}, 32'hf);
      for (int k = 0; k < 4; k++) expect_wave(k, per[k], dty[k], tk[k], pol[k]);
      while (wq.size() > 0) @(posedge clk_sys);
    end
    // stopped counter is cleared by any write
    wr(8'h63, 8'h00);
    wr(8'h67, 8'h9c);
    rd(8'h67, 32'h0);
    // both pairs joined; high channels enabled too, their pins stay released
    wr(8'h60, 8'hc0);
    wr(8'h61, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(JIDX[i], JVAL[i]);
      wr(JIDX[i] + 8'h02, JVAL[i]);
    end
    wr(8'h63, 8'h0f);
    wr(8'h65, 8'h33);
    wr(8'h67, 8'h33);
    repeat (600) @(posedge clk_sys);
    chk_rd({28'h0, pwm_pin_owned}, 32'ha);
    expect_wave(1, 'h105, 'h80, 1, 1'b0);
    expect_wave(3, 'h105, 'h80, 1, 1'b0);
    while (wq.size() > 0) @(posedge clk_sys);
    wr(8'h63, 8'h00);
    wr(8'h64, 8'h12);
    wr(8'h65, 8'h77);
    rd(8'h64, 32'h0);
    rd(8'h65, 32'h0);
    while (rq.size() > 0) @(posedge clk_sys);
    test_done;
  end
endmodule
